// ==== verilog/cvi_map.svh ====
`ifndef CVI_MAP_SVH
`define CVI_MAP_SVH
// Register byte offsets on the APB port.
`define CVI_OFF_WIN_END      12'h000
`define CVI_OFF_IRQ_CTRL     12'h004
`define CVI_OFF_MODE         12'h008
`define CVI_OFF_START2       12'h00c
`define CVI_OFF_STATUS       12'h010
`define CVI_OFF_IRQ_MASK     12'h014
`define CVI_OFF_COUNT        12'h018
// Field positions: high field and width shared by the window and interrupt registers, then interrupt-control enable and select bits.
`define CVI_HI_LSB           16
`define CVI_FIELD_W          12
`define CVI_BIT_F2_ENABLE    31
`define CVI_BIT_SYNC_SEL     30
`define CVI_BIT_F1_ENABLE    15
// Writable bit masks; everything else reads as zero except mode bit 2 (field 2 enable), status bit 3 (frame sync) and the read-only count register.
`define CVI_MASK_WIN         32'h0fff0ffe
`define CVI_MASK_IRQ_CTRL    32'hcfff8fff
`define CVI_MASK_MODE        32'h00000003
`define CVI_MASK_STATUS      32'h00000007
// Reset values.
`define CVI_RST_ZERO         32'h00000000
// Status bit positions.
`define CVI_ST_VIRQ          0
`define CVI_ST_F2_DONE       1
`define CVI_ST_F2_START      2
`define CVI_ST_SYNC          3
`endif

// ==== verilog/cvi_pkg.sv ====
package cvi_pkg;
    // Capture mode selected by software.
    typedef enum logic [1:0] {
        CVI_MODE_BT656 = 2'h0,
        CVI_MODE_YC    = 2'h1,
        CVI_MODE_RAW   = 2'h2,
        CVI_MODE_BYTES = 2'h3
    } cvi_mode_type;

    // Field 2 window state.
    typedef enum logic [1:0] {
        CVI_WIN_IDLE,
        CVI_WIN_ACTIVE,
        CVI_WIN_DONE
    } cvi_win_type;
endpackage

// ==== verilog/cvi_sync2.sv ====
`timescale 1ns/100ps
// Two-flop synchroniser for pin-side levels.
module cvi_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             clkEn,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_reg;

    // First stage is read only by the second stage.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else if (clkEn) begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end
endmodule

// ==== verilog/cvi_counters.sv ====
`timescale 1ns/100ps
// Pixel and line counters of the capture channel.
module cvi_counters #(
    parameter int CW = 12
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          clkEn,
    input  wire logic          active,
    input  wire logic          pixelValid,
    input  wire logic          hEvent,
    input  wire logic          vEvent,
    output logic      [CW-1:0] pixelCounter,
    output logic      [CW-1:0] lineCounter
);
    // R10 counter reset events
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pixelCounter <= '0;
        end else if (clkEn && active) begin
            if (hEvent) begin
                pixelCounter <= '0;
            end else if (pixelValid) begin
                pixelCounter <= pixelCounter + 1'b1;
            end
        end
    end

    // Lines advance on each horizontal event; vertical event restarts them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lineCounter <= '0;
        end else if (clkEn && active) begin
            if (vEvent) begin
                lineCounter <= '0;
            end else if (hEvent) begin
                lineCounter <= lineCounter + 1'b1;
            end
        end
    end
endmodule

// ==== verilog/cvi_capture_f2.sv ====
`timescale 1ns/100ps
`include "cvi_map.svh"
// Notes on behaviour
// R01 - Field 2 capture ends at the line held in the last-line field.
// R02 - Last pixel is field value minus one; its low bit reads as zero.
// R03 - Field 2 end register is ignored in raw and byte-stream modes.
// R04 - Reserved bits read zero and writes to them do nothing.
// R05 - In video modes, vertical interrupt fires at end of matching line.
// R06 - Two 12-bit interrupt-line fields, field 2 high, field 1 low, reset zero.
// R07 - Bit 15 enables field 1 interrupt, bit 31 field 2.
// R08 - Select bit zero: frame-sync flag cleared in field 1 at its line.
// R09 - Select bit one: frame-sync flag cleared in field 2 at its line.
// R10 - Pixel counter resets on horizontal event, line counter on vertical event.
// R11 - Field 2 capture starts at start pixel and start line when enabled.
// R12 - After last pixel of last line, nothing stored until next start.
module cvi_capture_f2 #(
    parameter int CW = 12
) (
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          clkEn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          vidValid,
    input  wire logic          vidHEvent,
    input  wire logic          vidVEvent,
    input  wire logic          vidField2,
    input  wire logic          frameSyncSet,
    output logic               sampleStore,
    output logic               frameSyncFlag,
    output logic               irq
);
    logic [31:0]         winEnd_reg;
    logic [31:0]         irqCtrl_reg;
    logic [31:0]         start2_reg;
    logic [31:0]         irqMask_reg;
    logic [2:0]          status_reg;
    logic                f2Enable_reg;
    cvi_pkg::cvi_mode_type mode_reg;
    cvi_pkg::cvi_win_type  win_reg;
    logic [3:0]          pinSync;
    logic                hEvtD_reg;
    logic                vidModeOk;
    logic [CW-1:0]       pixelCounter;
    logic [CW-1:0]       lineCounter;
    logic [CW-1:0]       lastLine;
    logic [CW-1:0]       lastPixel;
    logic [CW-1:0]       firstLine;
    logic [CW-1:0]       firstPixel;
    logic [CW-1:0]       f1IrqLine;
    logic [CW-1:0]       f2IrqLine;
    logic                inField2;
    logic                lineEnd;
    logic                irqLineHit;
    logic                syncClrHit;
    logic                startHit;
    logic                endHit;
    logic                wrEn;
    logic                rdEn;
    logic [2:0]          stEvents;

    // Pin-side video strobes pass two flops before any logic.
    cvi_sync2 #(
        .WIDTH (4)
    ) uSync (
        .clk     (clk),
        .nrst    (nrst),
        .clkEn   (clkEn),
        .asyncIn ({vidValid, vidHEvent, vidVEvent, vidField2}),
        .syncOut (pinSync)
    );

    assign inField2  = pinSync[0];
    // R03 video modes only
    assign vidModeOk = (mode_reg == cvi_pkg::CVI_MODE_BT656) || (mode_reg == cvi_pkg::CVI_MODE_YC);

    cvi_counters #(
        .CW (CW)
    ) uCnt (
        .clk          (clk),
        .nrst         (nrst),
        .clkEn        (clkEn),
        .active       (vidModeOk),
        .pixelValid   (pinSync[3]),
        .hEvent       (pinSync[2]),
        .vEvent       (pinSync[1]),
        .pixelCounter (pixelCounter),
        .lineCounter  (lineCounter)
    );

    // R01 last line field
    assign lastLine   = winEnd_reg[`CVI_HI_LSB +: CW];
    // R02 last pixel is even end value minus one
    assign lastPixel  = {winEnd_reg[CW-1:1], 1'b0} - 1'b1;
    assign firstLine  = start2_reg[`CVI_HI_LSB +: CW];
    assign firstPixel = {start2_reg[CW-1:1], 1'b0};
    // R06 interrupt line fields
    assign f1IrqLine  = irqCtrl_reg[CW-1:0];
    assign f2IrqLine  = irqCtrl_reg[`CVI_HI_LSB +: CW];

    // A line ends at the horizontal event that closes it; hold the event one cycle to find its first cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hEvtD_reg <= 1'b0;
        end else if (clkEn) begin
            hEvtD_reg <= pinSync[2];
        end
    end
    // The counter has not yet advanced at the event, so it still names the ending line.
    assign lineEnd = pinSync[2] && !hEvtD_reg;

    // R05 end of line match
    // R07 per field enables
    assign irqLineHit = vidModeOk && lineEnd &&
                        ((!inField2 && irqCtrl_reg[`CVI_BIT_F1_ENABLE] && lineCounter == f1IrqLine) ||
                         (inField2 && irqCtrl_reg[`CVI_BIT_F2_ENABLE] && lineCounter == f2IrqLine));

    // R08 clear in field 1
    // R09 clear in field 2
    assign syncClrHit = vidModeOk && lineEnd &&
                        (irqCtrl_reg[`CVI_BIT_SYNC_SEL] ? (inField2 && lineCounter == f2IrqLine)
                                                          : (!inField2 && lineCounter == f1IrqLine));

    // R11 start condition
    assign startHit = vidModeOk && f2Enable_reg && inField2 &&
                      pixelCounter == firstPixel && lineCounter == firstLine;
    // R12 end condition
    assign endHit   = pinSync[3] && pixelCounter == lastPixel && lineCounter == lastLine;

    // Field 2 window state machine.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            win_reg <= cvi_pkg::CVI_WIN_IDLE;
        end else if (clkEn) begin
            unique case (win_reg)
                cvi_pkg::CVI_WIN_IDLE: begin
                    if (startHit) begin
                        win_reg <= cvi_pkg::CVI_WIN_ACTIVE;
                    end
                end
                cvi_pkg::CVI_WIN_ACTIVE: begin
                    // R03 abandon outside video modes
                    if (!vidModeOk || !inField2) begin
                        win_reg <= cvi_pkg::CVI_WIN_IDLE;
                    end else if (endHit) begin
                        win_reg <= cvi_pkg::CVI_WIN_DONE;
                    end
                end
                cvi_pkg::CVI_WIN_DONE: begin
                    // R12 wait for next field or frame; a repeated field 2 frame restarts the window.
                    if (!inField2 || pinSync[1]) begin
                        win_reg <= cvi_pkg::CVI_WIN_IDLE;
                    end
                end
            endcase
        end
    end

    // Sample store strobe is a flop so it lines up with registered data downstream.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sampleStore <= 1'b0;
        end else if (clkEn) begin
            sampleStore <= pinSync[3] && ((win_reg == cvi_pkg::CVI_WIN_ACTIVE) || startHit);
        end
    end

    // Frame-sync flag: set by the source side, cleared at the chosen line; set wins.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frameSyncFlag <= 1'b0;
        end else if (clkEn) begin
            if (frameSyncSet) begin
                frameSyncFlag <= 1'b1;
            end else if (syncClrHit) begin
                frameSyncFlag <= 1'b0;
            end
        end
    end

    // APB: zero wait states, every access answered in the access phase.
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && !penable && !pwrite;

    // R04 reserved bits masked
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            winEnd_reg   <= `CVI_RST_ZERO;
            irqCtrl_reg  <= `CVI_RST_ZERO;
            start2_reg   <= `CVI_RST_ZERO;
            irqMask_reg  <= `CVI_RST_ZERO;
            mode_reg     <= cvi_pkg::CVI_MODE_BT656;
            f2Enable_reg <= 1'b0;
        end else if (clkEn && wrEn) begin
            unique case (paddr)
                `CVI_OFF_WIN_END:  winEnd_reg  <= pwdata & `CVI_MASK_WIN;
                `CVI_OFF_IRQ_CTRL: irqCtrl_reg <= pwdata & `CVI_MASK_IRQ_CTRL;
                `CVI_OFF_START2:   start2_reg  <= pwdata & `CVI_MASK_WIN;
                `CVI_OFF_IRQ_MASK: irqMask_reg <= pwdata & `CVI_MASK_STATUS;
                `CVI_OFF_MODE: begin
                    mode_reg     <= cvi_pkg::cvi_mode_type'(pwdata[1:0]);
                    f2Enable_reg <= pwdata[2];
                end
                default: ;
            endcase
        end
    end

    // Sticky events: vertical irq, field 2 done, field 2 start.
    assign stEvents = {startHit && win_reg == cvi_pkg::CVI_WIN_IDLE,
                       endHit && win_reg == cvi_pkg::CVI_WIN_ACTIVE,
                       irqLineHit};

    // Write one to clear; a new event in the same cycle wins over the clear.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= 3'h0;
        end else if (clkEn) begin
            if (wrEn && paddr == `CVI_OFF_STATUS) begin
                status_reg <= (status_reg & ~pwdata[2:0]) | stEvents;
            end else begin
                status_reg <= status_reg | stEvents;
            end
        end
    end

    assign irq = |(status_reg & irqMask_reg[2:0]);

    // Read data registered in the setup phase, valid in the access phase.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0;
        end else if (clkEn && rdEn) begin
            unique case (paddr)
                `CVI_OFF_WIN_END:  prdata <= winEnd_reg;
                `CVI_OFF_IRQ_CTRL: prdata <= irqCtrl_reg;
                `CVI_OFF_START2:   prdata <= start2_reg;
                `CVI_OFF_IRQ_MASK: prdata <= irqMask_reg;
                `CVI_OFF_MODE:     prdata <= {29'h0, f2Enable_reg, mode_reg};
                `CVI_OFF_STATUS:   prdata <= {28'h0, frameSyncFlag, status_reg};
                `CVI_OFF_COUNT:    prdata <= {4'h0, lineCounter, 4'h0, pixelCounter};
                default:           prdata <= 32'h0;
            endcase
        end
    end
endmodule

// ==== sim/cvi_capture_f2_chk.sv ====
`timescale 1ns/100ps
// Port-level checks of the field 2 window and vertical interrupt block.
module cvi_capture_f2_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        clkEn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        vidValid,
    input wire logic        vidHEvent,
    input wire logic        vidVEvent,
    input wire logic        vidField2,
    input wire logic        frameSyncSet,
    input wire logic        sampleStore,
    input wire logic        frameSyncFlag,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Read access phase; the window allows for the two-flop pin latency.
    wire rdAcc = psel && penable && !pwrite;
    a_ready_always: assert property (pready) else $error("pready low");
    a_no_slverr: assert property (!pslverr) else $error("pslverr high");
    a_end_rsv_zero: assert property (rdAcc && paddr == 12'h000 |-> (prdata & 32'hf000f001) == '0)
        else $error("window end shows reserved or odd bits");
    a_ctrl_rsv_zero: assert property (rdAcc && paddr == 12'h004 |-> (prdata & 32'h30007000) == '0)
        else $error("interrupt control shows reserved bits");
    a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("read data moved");
    a_sync_set_wins: assert property (frameSyncSet |=> frameSyncFlag) else $error("sync flag not set");
    a_sync_rise_cause: assert property ($rose(frameSyncFlag) |-> $past(frameSyncSet)) else $error("sync flag rose");
    a_sync_fall_cause: assert property ($fell(frameSyncFlag) |-> !$past(frameSyncSet) &&
        ($past(vidHEvent, 2) || $past(vidHEvent, 3) || $past(vidHEvent, 4))) else $error("sync flag fell");
    a_store_in_field2: assert property (sampleStore |-> $past(vidField2, 3) &&
        ($past(vidValid, 2) || $past(vidValid, 3) || $past(vidValid, 4))) else $error("stray sample store");
    c_sync_cleared: cover property ($fell(frameSyncFlag));
    c_irq_raised: cover property ($rose(irq));
    c_sample_stored: cover property (sampleStore);
endmodule
bind cvi_capture_f2 cvi_capture_f2_chk chk (.clk(clk), .nrst(nrst), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vidValid(vidValid), .vidHEvent(vidHEvent), .vidVEvent(vidVEvent), .vidField2(vidField2),
    .frameSyncSet(frameSyncSet), .sampleStore(sampleStore), .frameSyncFlag(frameSyncFlag), .irq(irq));

// ==== sim/cvi_vid_src.sv ====
`timescale 1ns/100ps
// Far-side video source: eight samples a line, each line closed by a horizontal event.
module cvi_vid_src (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       start,
    input  wire logic       field2,
    input  wire logic [3:0] lines,
    output logic            vidValid,
    output logic            vidHEvent,
    output logic            vidVEvent,
    output logic            vidField2,
    output logic            busy
);
    logic [3:0] pix;
    logic [3:0] line;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {vidValid, vidHEvent, vidVEvent, vidField2, busy, pix, line} <= '0;
        end else if (!busy) begin
            busy      <= start;
            vidVEvent <= start;
            vidField2 <= start ? field2 : vidField2;
            pix       <= '0;
            line      <= '0;
        end else begin
            vidVEvent <= 1'b0;
            vidValid  <= pix < 4'h8;
            vidHEvent <= pix == 4'h8;
            pix       <= (pix == 4'h9) ? 4'h0 : pix + 4'h1;
            line      <= line + {3'h0, pix == 4'h9};
            busy      <= !(pix == 4'h9 && line == lines - 4'h1);
        end
    end
endmodule

// ==== sim/cvi_capture_f2_tb.sv ====
`timescale 1ns/100ps
`include "cvi_map.svh"
module cvi_capture_f2_tb;
    logic        clk, nrst, clkEn, psel, penable, pwrite, frameSyncSet, start, fld, busy;
    logic        pready, pslverr, vidValid, vidHEvent, vidVEvent, vidField2, sampleStore, frameSyncFlag, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, w;
    logic [3:0]  lines;
    int          num_errors, cmp_count, stores;
    cvi_capture_f2 dut (.clk(clk), .nrst(nrst), .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .vidValid(vidValid),
        .vidHEvent(vidHEvent), .vidVEvent(vidVEvent), .vidField2(vidField2), .frameSyncSet(frameSyncSet),
        .sampleStore(sampleStore), .frameSyncFlag(frameSyncFlag), .irq(irq));
    cvi_vid_src src (.clk(clk), .nrst(nrst), .start(start), .field2(fld), .lines(lines), .vidValid(vidValid),
        .vidHEvent(vidHEvent), .vidVEvent(vidVEvent), .vidField2(vidField2), .busy(busy));
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Samples stored from one field 2 line: the low bit of the end value is dropped.
    function automatic logic [31:0] exp_cnt(input logic [31:0] v);
        return v & 32'hffe;
    endfunction
    // Compare and count; a mismatch is reported at once.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    // One APB transfer, held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        d = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Let the write settle before the caller looks at outputs.
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), e, d);
    endtask
    // Play one frame and let the pin synchronisers drain.
    task automatic run(input logic f, input logic [3:0] n);
        @(posedge clk);
        start <= 1'b1;
        fld   <= f;
        lines <= n;
        @(posedge clk);
        start <= 1'b0;
        #1;
        for (int i = 0; i < 300 && busy; i++) begin
            @(posedge clk);
            #1;
        end
        // A frame that never ends is a failure, not a silent pass.
        if (busy !== 1'b0) begin
            num_errors++;
            $display("[FAIL] frame end expected 0 seen %b", busy);
        end
        repeat (8) @(posedge clk);
        #1;
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Count the stores the block makes during a frame.
    always @(posedge clk) begin
        if (sampleStore === 1'b1) stores++;
    end
    // A hang is cut short well after the tests should have ended.
    initial begin
        #500000;
        num_errors++;
        stop_test();
    end
    initial begin
        {nrst, psel, penable, pwrite, frameSyncSet, start, fld} = '0;
        {clkEn, paddr, pwdata, lines, num_errors, cmp_count, stores} = {1'b1, 48'h0, 96'h0};
        w = $urandom(79);
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rd(`CVI_OFF_WIN_END, 32'h0);
        rd(`CVI_OFF_IRQ_CTRL, 32'h0);
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            apb(1'b1, `CVI_OFF_WIN_END, w);
            rd(`CVI_OFF_WIN_END, w & 32'h0fff0ffe);
            apb(1'b1, `CVI_OFF_IRQ_CTRL, w);
            rd(`CVI_OFF_IRQ_CTRL, w & `CVI_MASK_IRQ_CTRL);
        end
        apb(1'b1, 12'h01c, w);
        rd(12'h01c, 32'h0);
        $display("registers test done");
        apb(1'b1, `CVI_OFF_IRQ_MASK, 32'h1);
        for (int m = 0; m < 4; m++) begin
            for (int f = 0; f < 2; f++) begin
                apb(1'b1, `CVI_OFF_MODE, m);
                apb(1'b1, `CVI_OFF_IRQ_CTRL, f ? 32'h80020000 : 32'h00008002);
                run(!f, 4);
                chk("irq other field", 0, irq);
                run(f, 4);
                chk("irq", m < 2, irq);
                apb(1'b1, `CVI_OFF_IRQ_MASK, 32'h0);
                chk("irq masked", 0, irq);
                rd(`CVI_OFF_STATUS, m < 2);
                apb(1'b1, `CVI_OFF_STATUS, 32'h7);
                apb(1'b1, `CVI_OFF_IRQ_MASK, 32'h1);
                chk("irq cleared", 0, irq);
            end
        end
        $display("vertical interrupt test done");
        apb(1'b1, `CVI_OFF_MODE, 32'h0);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `CVI_OFF_IRQ_CTRL, s ? 32'h40010000 : 32'h00000001);
            @(posedge clk);
            frameSyncSet <= 1'b1;
            @(posedge clk);
            frameSyncSet <= 1'b0;
            #1;
            chk("sync set", 1, frameSyncFlag);
            run(!s, 4);
            chk("sync kept", 1, frameSyncFlag);
            run(s, 4);
            chk("sync cleared", 0, frameSyncFlag);
        end
        $display("frame sync test done");
        apb(1'b1, `CVI_OFF_START2, 32'h00010000);
        // Last two passes: capture disabled, then raw mode with field 2 enabled; both store nothing.
        for (int k = 0; k < 5; k++) begin
            w = 2 + $urandom % 7;
            apb(1'b1, `CVI_OFF_WIN_END, 32'h00010000 | w);
            apb(1'b1, `CVI_OFF_MODE, k < 3 ? 32'h4 : (k == 3 ? 32'h0 : 32'h6));
            stores = 0;
            run(1'b1, 3);
            chk("stores", k < 3 ? exp_cnt(w) : 0, stores);
            rd(`CVI_OFF_STATUS, k < 3 ? 32'h6 : 32'h0);
            apb(1'b1, `CVI_OFF_STATUS, 32'h7);
        end
        $display("field 2 window test done");
        stop_test();
    end
endmodule
